// *** design/eew_pkg.sv ***
`default_nettype none
package eew_pkg;
    localparam int EEW_CLK_MHZ = 100;
    localparam int EEW_T_PROG_US = 100;
    localparam int EEW_T_ERPG_US = 1500;
    localparam int EEW_PROG_CYC = EEW_T_PROG_US * EEW_CLK_MHZ;
    localparam int EEW_ERPG_CYC = EEW_T_ERPG_US * EEW_CLK_MHZ;
    localparam int EEW_DEPTH = 16;
    localparam int EEW_DATA_W = 16;
    localparam int EEW_ST_W = 2;
    // record state codes; bits fall from erased to started to done, but retiring a record to stale sets bit 0
    localparam logic [1:0] EEW_ST_ERASED = 2'h3;
    localparam logic [1:0] EEW_ST_STARTED = 2'h2;
    localparam logic [1:0] EEW_ST_STALE = 2'h1;
    localparam logic [1:0] EEW_ST_DONE = 2'h0;

    typedef enum logic [4:0] {
        EEW_S_SCAN = 5'h01,
        EEW_S_IDLE = 5'h02,
        EEW_S_CLEAN = 5'h04,
        EEW_S_LAUNCH = 5'h08,
        EEW_S_PROG = 5'h10
    } eew_state_t;
endpackage
`default_nettype wire

// *** design/eew_rec_eval.sv ***
`timescale 1ns/1ps
`default_nettype none
module eew_rec_eval
    import eew_pkg::*;
#(
    parameter int DATA_W = EEW_DATA_W
) (
    // the two backup records of one address
    input wire logic [DATA_W+1:0] rec0,
    input wire logic [DATA_W+1:0] rec1,
    // verdict
    output logic valid,
    output logic sel,
    output logic [DATA_W-1:0] data,
    output logic incompl0,
    output logic incompl1
);
    logic done0;
    logic done1;

    always_comb begin
        done0 = rec0[DATA_W+1:DATA_W] == EEW_ST_DONE;
        done1 = rec1[DATA_W+1:DATA_W] == EEW_ST_DONE;
        incompl0 = rec0[DATA_W+1:DATA_W] == EEW_ST_STARTED;
        incompl1 = rec1[DATA_W+1:DATA_W] == EEW_ST_STARTED;
        valid = done0 | done1;
        sel = done1 & ~done0;
        // no finished record means the location reads as erased
        if (done0) begin
            data = rec0[DATA_W-1:0];
        end else if (done1) begin
            data = rec1[DATA_W-1:0];
        end else begin
            data = '1;
        end
    end
endmodule
`default_nettype wire

// *** design/eew_store.sv ***
`timescale 1ns/1ps
`default_nettype none
module eew_store
    import eew_pkg::*;
#(
    parameter int DATA_W = EEW_DATA_W,
    parameter int DEPTH = EEW_DEPTH,
    parameter int PROG_CYC = EEW_PROG_CYC,
    parameter int ERPG_CYC = EEW_ERPG_CYC,
    localparam int AW = $clog2(DEPTH),
    localparam int CW = $clog2(ERPG_CYC + 1),
    localparam int RW = DATA_W + EEW_ST_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // host write
    input wire logic wr_req,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    // host read
    input wire logic rd_req,
    input wire logic [AW-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data,
    // status
    output logic store_ready_flag,
    output logic command_complete_flag
);
    // nonvolatile backup records, two slots per address; never reset
    // the array leaves the factory erased, so the first scan finds no records
    logic [RW-1:0] rec_mem [DEPTH][2] = '{default: '1};
    logic [DATA_W-1:0] ram_mem [DEPTH];

    eew_state_t state_reg, state_next;
    logic [AW-1:0] idx_reg, idx_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [CW-1:0] lim_reg, lim_next;
    logic [AW-1:0] job_addr_reg, job_addr_next;
    logic [DATA_W-1:0] job_data_reg, job_data_next;
    logic job_slot_reg, job_slot_next;
    logic [DEPTH-1:0] vslot_reg, vslot_next;
    logic [DEPTH-1:0] vhas_reg, vhas_next;
    logic [2*DEPTH-1:0] comp_reg, comp_next;
    logic ready_reg, ready_next;
    logic ccf_reg, ccf_next;
    logic [DATA_W-1:0] rd_reg, rd_next;

    // memory write strobes
    logic [1:0] rw_en;
    logic [AW-1:0] rw_addr;
    logic [RW-1:0] rw_val0;
    logic [RW-1:0] rw_val1;
    logic ram_we;
    logic [AW-1:0] ram_wa;
    logic [DATA_W-1:0] ram_wd;

    logic ev_valid;
    logic ev_sel;
    logic [DATA_W-1:0] ev_data;
    logic ev_inc0;
    logic ev_inc1;
    logic [AW:0] clean_idx;
    logic wr_take;

    function automatic logic [RW-1:0] mk_rec(input logic [1:0] st, input logic [DATA_W-1:0] d);
        mk_rec = {st, d};
    endfunction

    function automatic logic [AW:0] first_set(input logic [2*DEPTH-1:0] v);
        first_set = '0;
        for (int i = 2 * DEPTH - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = (AW + 1)'(i);
            end
        end
    endfunction

    eew_rec_eval #(
        .DATA_W(DATA_W)
    ) u_eval (
        .rec0(rec_mem[idx_reg][0]),
        .rec1(rec_mem[idx_reg][1]),
        .valid(ev_valid),
        .sel(ev_sel),
        .data(ev_data),
        .incompl0(ev_inc0),
        .incompl1(ev_inc1)
    );

    assign wr_take = (state_reg == EEW_S_IDLE) && wr_req;

    always_comb begin
        state_next = state_reg;
        idx_next = idx_reg;
        cnt_next = cnt_reg;
        lim_next = lim_reg;
        job_addr_next = job_addr_reg;
        job_data_next = job_data_reg;
        job_slot_next = job_slot_reg;
        vslot_next = vslot_reg;
        vhas_next = vhas_reg;
        comp_next = comp_reg;
        ready_next = ready_reg;
        ccf_next = ccf_reg;
        rd_next = rd_reg;
        rw_en = 2'b00;
        rw_addr = job_addr_reg;
        rw_val0 = '1;
        rw_val1 = '1;
        ram_we = 1'b0;
        ram_wa = job_addr_reg;
        ram_wd = job_data_reg;
        clean_idx = first_set(comp_reg);
        if (ready_reg && rd_req) begin
            rd_next = ram_mem[rd_addr];
        end
        unique case (state_reg)
            EEW_S_SCAN: begin
                // any reset lands here, so a brownout and a plain reset are alike
                rw_addr = idx_reg;
                rw_val0 = mk_rec(EEW_ST_STALE, rec_mem[idx_reg][0][DATA_W-1:0]);
                rw_val1 = mk_rec(EEW_ST_STALE, rec_mem[idx_reg][1][DATA_W-1:0]);
                rw_en = {ev_inc1, ev_inc0};
                comp_next[2*idx_reg] = comp_reg[2*idx_reg] | ev_inc0;
                comp_next[2*idx_reg+1] = comp_reg[2*idx_reg+1] | ev_inc1;
                ram_we = 1'b1;
                ram_wa = idx_reg;
                ram_wd = ev_data;
                vslot_next[idx_reg] = ev_sel;
                vhas_next[idx_reg] = ev_valid;
                if (idx_reg == AW'(DEPTH - 1)) begin
                    state_next = EEW_S_IDLE;
                    ready_next = 1'b1;
                    ccf_next = 1'b1;
                end else begin
                    idx_next = idx_reg + AW'(1);
                end
            end
            EEW_S_IDLE: begin
                if (wr_req) begin
                    ram_we = 1'b1;
                    ram_wa = wr_addr;
                    ram_wd = wr_data;
                    job_addr_next = wr_addr;
                    job_data_next = wr_data;
                    ready_next = 1'b0;
                    ccf_next = 1'b0;
                    state_next = (comp_reg != '0) ? EEW_S_CLEAN : EEW_S_LAUNCH;
                end
            end
            EEW_S_CLEAN: begin
                // drop one compromised record per cycle; the valid twin remains
                rw_addr = clean_idx[AW:1];
                rw_en = clean_idx[0] ? 2'b10 : 2'b01;
                comp_next[clean_idx] = 1'b0;
                if ((comp_reg & (comp_reg - 1'b1)) == '0) begin
                    state_next = EEW_S_LAUNCH;
                end
            end
            EEW_S_LAUNCH: begin
                if (job_data_reg == '1) begin
                    rw_en = 2'b11;
                    vhas_next[job_addr_reg] = 1'b0;
                    state_next = EEW_S_IDLE;
                    ready_next = 1'b1;
                    ccf_next = 1'b1;
                end else begin
                    job_slot_next = vhas_reg[job_addr_reg] & ~vslot_reg[job_addr_reg];
                    rw_en = job_slot_next ? 2'b10 : 2'b01;
                    rw_val0 = mk_rec(EEW_ST_STARTED, job_data_reg);
                    rw_val1 = rw_val0;
                    if (rec_mem[job_addr_reg][job_slot_next][DATA_W+1:DATA_W] == EEW_ST_ERASED) begin
                        lim_next = CW'(PROG_CYC);
                    end else begin
                        lim_next = CW'(ERPG_CYC);
                    end
                    cnt_next = '0;
                    state_next = EEW_S_PROG;
                end
            end
            EEW_S_PROG: begin
                cnt_next = cnt_reg + CW'(1);
                if (cnt_reg == lim_reg - CW'(1)) begin
                    // new record finished and old one retired in the same cycle
                    rw_val0 = mk_rec(job_slot_reg ? EEW_ST_STALE : EEW_ST_DONE,
                        rec_mem[job_addr_reg][0][DATA_W-1:0]);
                    rw_val1 = mk_rec(job_slot_reg ? EEW_ST_DONE : EEW_ST_STALE,
                        rec_mem[job_addr_reg][1][DATA_W-1:0]);
                    rw_en = vhas_reg[job_addr_reg] ? 2'b11 : (job_slot_reg ? 2'b10 : 2'b01);
                    vslot_next[job_addr_reg] = job_slot_reg;
                    vhas_next[job_addr_reg] = 1'b1;
                    state_next = EEW_S_IDLE;
                    ready_next = 1'b1;
                    ccf_next = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= EEW_S_SCAN;
            idx_reg <= '0;
            cnt_reg <= '0;
            lim_reg <= '0;
            job_addr_reg <= '0;
            job_data_reg <= '0;
            job_slot_reg <= 1'b0;
            vslot_reg <= '0;
            vhas_reg <= '0;
            comp_reg <= '0;
            ready_reg <= 1'b0;
            ccf_reg <= 1'b0;
            rd_reg <= '0;
        end else begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            cnt_reg <= cnt_next;
            lim_reg <= lim_next;
            job_addr_reg <= job_addr_next;
            job_data_reg <= job_data_next;
            job_slot_reg <= job_slot_next;
            vslot_reg <= vslot_next;
            vhas_reg <= vhas_next;
            comp_reg <= comp_next;
            ready_reg <= ready_next;
            ccf_reg <= ccf_next;
            rd_reg <= rd_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rw_en[0]) begin
            rec_mem[rw_addr][0] <= rw_val0;
        end
        if (rw_en[1]) begin
            rec_mem[rw_addr][1] <= rw_val1;
        end
        if (ram_we) begin
            ram_mem[ram_wa] <= ram_wd;
        end
    end

    assign rd_data = rd_reg;
    assign store_ready_flag = ready_reg;
    assign command_complete_flag = ccf_reg;

    a_ready_in_scan: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_reg == EEW_S_SCAN) |-> !store_ready_flag)
        else $error("store ready while start-up copy runs");
    a_no_early_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_reg == EEW_S_SCAN) |=> (state_reg != EEW_S_LAUNCH && state_reg != EEW_S_PROG))
        else $error("write serviced before record check");
    a_prog_short: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_reg == EEW_S_LAUNCH && job_data_reg != '1
         && rec_mem[job_addr_reg][job_slot_next][DATA_W+1:DATA_W] == EEW_ST_ERASED)
        |=> lim_reg == CW'(PROG_CYC))
        else $error("program to erased slot not on short timing");
    a_erpg_bound: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_reg == EEW_S_PROG) |-> (cnt_reg < lim_reg && lim_reg <= CW'(ERPG_CYC)))
        else $error("backup operation overran its time");
    a_mark_comp: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_reg == EEW_S_SCAN && ev_inc0)
        |=> (rec_mem[$past(idx_reg)][0][DATA_W+1:DATA_W] == EEW_ST_STALE
             && comp_reg[2*$past(idx_reg)]))
        else $error("half-written record not flagged");
    a_mark_comp_hi: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_reg == EEW_S_SCAN && ev_inc1)
        |=> (rec_mem[$past(idx_reg)][1][DATA_W+1:DATA_W] == EEW_ST_STALE
             && comp_reg[2*$past(idx_reg)+1]))
        else $error("half-written spare record not flagged");
    a_replace_comp: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_take && comp_reg != '0 |=> state_reg == EEW_S_CLEAN ##1 !comp_reg[$past(clean_idx)])
        else $error("compromised record not replaced on next write");
    a_pre_erase: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_reg == EEW_S_LAUNCH && job_data_reg == '1)
        |=> (command_complete_flag && !vhas_reg[job_addr_reg]))
        else $error("all-ones write did not pre-erase");
    a_busy_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_take |=> !command_complete_flag && !store_ready_flag)
        else $error("flags not lowered while backup runs");
    a_ram_load: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_reg == EEW_S_SCAN) |=> ram_mem[$past(idx_reg)] == $past(ev_data))
        else $error("store not loaded with last valid value");
endmodule
`default_nettype wire

// *** test/eew_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module eew_host_model
    import eew_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // write side
    output logic wr_req,
    output logic [3:0] wr_addr,
    output logic [EEW_DATA_W-1:0] wr_data,
    // read side
    output logic rd_req,
    output logic [3:0] rd_addr,
    input wire logic [EEW_DATA_W-1:0] rd_data,
    // status
    input wire logic store_ready_flag
);
    initial begin
        wr_req = 1'b0;
        rd_req = 1'b0;
        wr_addr = 4'h0;
        wr_data = 16'h0;
        rd_addr = 4'h0;
    end

    // released lines flip so a stale value never passes for a live one
    task automatic release_lines();
        wr_addr = ~wr_addr;
        wr_data = ~wr_data;
        rd_addr = ~rd_addr;
    endtask

    task automatic wait_ready(input int limit, output int cyc);
        cyc = 0;
        while (store_ready_flag !== 1'b1 && cyc < limit) begin
            @(negedge clk_sys);
            cyc++;
        end
    endtask

    task automatic issue_write(input logic [3:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        wr_req = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge clk_sys);
        wr_req = 1'b0;
        release_lines();
    endtask

    // stays off the store until the backup operation ends
    task automatic do_write(input logic [3:0] a, input logic [15:0] d, output int cyc);
        issue_write(a, d);
        @(negedge clk_sys);
        wait_ready(400, cyc);
    endtask

    task automatic do_read(input logic [3:0] a, output logic [15:0] d);
        @(negedge clk_sys);
        rd_req = 1'b1;
        rd_addr = a;
        @(negedge clk_sys);
        rd_req = 1'b0;
        release_lines();
        @(negedge clk_sys);
        d = rd_data;
    endtask
endmodule
`default_nettype wire

// *** test/eeprom_emulation_write_recovery_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module eeprom_emulation_write_recovery_tb_top;
    import eew_pkg::*;
    localparam int PROG = 8;
    localparam int ERPG = 30;
    logic clk_sys;
    logic arst_n;
    logic wr_req;
    logic rd_req;
    logic [3:0] wr_addr;
    logic [3:0] rd_addr;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    logic store_ready_flag;
    logic command_complete_flag;
    logic [15:0] ref_mem [16];
    logic [15:0] lfsr_state;
    int fails;
    int n_compared;

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    eew_store #(.PROG_CYC(PROG), .ERPG_CYC(ERPG)) u_dut (
        .clk_sys(clk_sys), .arst_n(arst_n),
        .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
        .store_ready_flag(store_ready_flag),
        .command_complete_flag(command_complete_flag)
    );

    eew_host_model u_host (
        .clk_sys(clk_sys), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
        .store_ready_flag(store_ready_flag)
    );

    // never all-ones, so random data never turns into a pre-erase
    function automatic logic [15:0] next_data();
        lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12] ^ lfsr_state[10]};
        return lfsr_state & 16'h7fff;
    endfunction

    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic apply_reset(input int cyc);
        int w;
        @(negedge clk_sys);
        arst_n = 1'b0;
        repeat (cyc) @(negedge clk_sys);
        check(rd_data === 16'h0 && store_ready_flag === 1'b0, "outputs in reset");
        check(command_complete_flag === 1'b0, "complete flag in reset");
        arst_n = 1'b1;
        repeat (15) begin
            @(negedge clk_sys);
            check(store_ready_flag === 1'b0, "ready before load done");
        end
        u_host.wait_ready(10, w);
        check(store_ready_flag === 1'b1, "ready after load");
        check(command_complete_flag === 1'b1, "complete after load");
    endtask

    task automatic check_all();
        logic [15:0] d;
        for (int a = 0; a < 16; a++) begin
            u_host.do_read(a[3:0], d);
            check(d === ref_mem[a], "read value");
        end
    endtask

    task automatic write_chk(input logic [3:0] a, input logic [15:0] d, input int lo, input int hi);
        int cyc;
        u_host.do_write(a, d, cyc);
        ref_mem[a] = d;
        check(cyc >= lo && cyc <= hi, "write duration");
        check(command_complete_flag === 1'b1, "complete after write");
    endtask

    initial begin
        #200000;
        fails++;
        tally_and_finish();
    end

    initial begin
        logic [3:0] a;
        logic [15:0] d;
        logic [15:0] prev;
        int w;
        arst_n = 1'b0;
        fails = 0;
        n_compared = 0;
        lfsr_state = 16'h0015;
        for (int i = 0; i < 16; i++) begin
            ref_mem[i] = 16'hffff;
        end
        apply_reset(8);
        check_all();
        // erased spare, erased spare, then a spare that needs an erase
        write_chk(4'h3, next_data(), PROG, PROG + 4);
        write_chk(4'h3, next_data(), PROG, PROG + 4);
        write_chk(4'h3, next_data(), PROG + 5, ERPG + 4);
        write_chk(4'h3, 16'hffff, 0, 4);
        write_chk(4'h3, next_data(), PROG, PROG + 4);
        // requests while busy are ignored
        u_host.do_read(4'h3, prev);
        d = next_data();
        u_host.issue_write(4'h9, d);
        ref_mem[9] = d;
        u_host.issue_write(4'ha, 16'h0bad);
        u_host.do_read(4'h9, d);
        check(d === prev, "read refused while busy");
        u_host.wait_ready(ERPG + 10, w);
        check_all();
        // reset at two points of a write; the later cut lands in the first slot
        for (int k = 2; k <= 6; k += 4) begin
            a = 4'h5 + k[3:0];
            write_chk(a, next_data(), PROG, ERPG + 4);
            if (k > 2) begin
                write_chk(a, next_data(), PROG, PROG + 4);
            end
            u_host.issue_write(a, next_data());
            repeat (k) @(negedge clk_sys);
            apply_reset(2);
            check_all();
            write_chk(4'hc, next_data(), PROG, ERPG + 6);
            check_all();
            apply_reset(2);
            check_all();
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
